/* src/csr_sideband.sv */
// Contract
// - Strap input picks processor family; zero first family, one second.
// - Strap one drives init and reset outputs active low outside reset; during reset, init is low and reset high, as for strap zero.
// - Strap zero drives init and reset outputs active high.
// - Strap zero latches sideband outputs other than reset during stop-clock, plus five clocks.
// - Strap one passes sideband signals straight through unlatched.
// - Reset port write with bits two and one set starts hard reset.
// - Hard reset drives suspend outputs low three to four RTC periods.
// - Power-good kept: normal finish; power-good lost: cold boot sequence.
`timescale 1ns/10ps
`default_nettype none
`include "csr_cfg.svh"
module csr_sideband (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Strap and stop-clock
  input  wire logic       proc_type_strap,
  input  wire logic       stop_clock_req,
  // Live sideband sources, active high
  input  wire logic       nmi_src,
  input  wire logic       mgmt_irq_src,
  input  wire logic       cpu_irq_src,
  input  wire logic       init_src,
  input  wire logic       reset_src,
  // Reset-control port write
  input  wire logic       rst_port_wr,
  input  wire logic [7:0] rst_port_data,
  // RTC tick and power-good
  input  wire logic       rtc_tick,
  input  wire logic       power_good,
  // Processor sideband outputs
  output logic            nmi_out,
  output logic            mgmt_irq_out,
  output logic            cpu_irq_out,
  output logic            cpu_init_out,
  output logic            cpu_reset_out,
  // Suspend planes, low during pulse
  output logic            suspend_plane_a,
  output logic            suspend_plane_b,
  output logic            suspend_plane_c,
  // Restart indications
  output logic            hard_reset_done,
  output logic            cold_boot_start
);
  logic                  strap_r;
  logic                  hold_r;
  logic [2:0]            hold_cnt_r;
  logic [3:0]            lat_r;
  logic [3:0]            live;
  logic [3:0]            eff;
  logic                  rst_eff;
  logic [2:0]            rtc_cnt_r;
  logic                  pg_lost_r;
  logic                  hard_go;
  logic                  pulse_end;
  logic                  sus_nxt;
  csr_pkg::csr_state_t   st_r;

  assign live = {nmi_src, mgmt_irq_src, cpu_irq_src, init_src};
  assign hard_go = rst_port_wr && rst_port_data[`CSR_HARD_BIT]
                   && rst_port_data[`CSR_SYS_BIT];

  // Strap caught in the clock domain
  always_ff @(posedge clock) begin
    if (rst) strap_r <= `CSR_FAM_A;
    else strap_r <= proc_type_strap;
  end

  // Hold window during stop-clock plus trailing count
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_r <= 1'b0;
      hold_cnt_r <= 3'h0;
    end else if (strap_r != `CSR_FAM_A) begin
      hold_r <= 1'b0;
      hold_cnt_r <= 3'h0;
    end else if (stop_clock_req) begin
      hold_r <= 1'b1;
      hold_cnt_r <= `CSR_HOLD_CLKS;
    end else if (hold_cnt_r != 3'h0) begin
      hold_cnt_r <= hold_cnt_r - 3'h1;
      hold_r <= (hold_cnt_r != 3'h1);
    end else begin
      hold_r <= 1'b0;
    end
  end

  // Latch captures values on entry into hold
  always_ff @(posedge clock) begin
    if (rst) lat_r <= 4'h0;
    else if (!hold_r) lat_r <= live;
  end

  assign eff = (hold_r && strap_r == `CSR_FAM_A) ? lat_r : live;
  assign rst_eff = reset_src || (st_r != csr_pkg::CSR_IDLE);

  // Registered sideband outputs with polarity from strap
  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_out <= 1'b0;
      mgmt_irq_out <= 1'b0;
      cpu_irq_out <= 1'b0;
      cpu_init_out <= 1'b0;
      cpu_reset_out <= 1'b1;
    end else begin
      nmi_out <= eff[3];
      mgmt_irq_out <= eff[2];
      cpu_irq_out <= eff[1];
      if (strap_r == `CSR_FAM_B) begin
        cpu_init_out <= ~eff[0];
        cpu_reset_out <= ~rst_eff;
      end else begin
        cpu_init_out <= eff[0];
        cpu_reset_out <= rst_eff;
      end
    end
  end

  // Hard reset sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= csr_pkg::CSR_IDLE;
      rtc_cnt_r <= 3'h0;
      pg_lost_r <= 1'b0;
      hard_reset_done <= 1'b0;
      cold_boot_start <= 1'b0;
    end else begin
      hard_reset_done <= 1'b0;
      cold_boot_start <= 1'b0;
      case (st_r)
        csr_pkg::CSR_IDLE: begin
          if (hard_go) begin
            st_r <= csr_pkg::CSR_PULSE;
            rtc_cnt_r <= 3'h0;
            pg_lost_r <= 1'b0;
          end
        end
        csr_pkg::CSR_PULSE: begin
          if (!power_good) pg_lost_r <= 1'b1;
          if (rtc_tick) rtc_cnt_r <= rtc_cnt_r + 3'h1;
          if (rtc_tick && rtc_cnt_r == `CSR_SUS_RTC - 3'h1) begin
            if (pg_lost_r || !power_good) begin
              st_r <= csr_pkg::CSR_COLD;
            end else begin
              st_r <= csr_pkg::CSR_IDLE;
              hard_reset_done <= 1'b1;
            end
          end
        end
        csr_pkg::CSR_COLD: begin
          if (power_good) begin
            st_r <= csr_pkg::CSR_IDLE;
            cold_boot_start <= 1'b1;
          end
        end
        default: st_r <= csr_pkg::CSR_IDLE;
      endcase
    end
  end

  // Pulse low from the write edge onward; busy writes are ignored
  assign pulse_end = rtc_tick && (rtc_cnt_r == `CSR_SUS_RTC - 3'h1);
  assign sus_nxt = !((hard_go && (st_r == csr_pkg::CSR_IDLE))
                     || ((st_r == csr_pkg::CSR_PULSE) && !pulse_end));
  always_ff @(posedge clock) begin
    if (rst) begin
      suspend_plane_a <= 1'b1;
      suspend_plane_b <= 1'b1;
      suspend_plane_c <= 1'b1;
    end else begin
      suspend_plane_a <= sus_nxt;
      suspend_plane_b <= sus_nxt;
      suspend_plane_c <= sus_nxt;
    end
  end

  property p_bpass;
    @(posedge clock) disable iff (rst)
      (strap_r == `CSR_FAM_B) |=> (nmi_out == $past(nmi_src));
  endproperty
  a_bpass: assert property (p_bpass) else $error("pass through");

  property p_hold;
    @(posedge clock) disable iff (rst)
      hold_r && $stable(hold_r) && (strap_r == `CSR_FAM_A)
        |=> (nmi_out == $past(lat_r[3]));
  endproperty
  a_hold: assert property (p_hold) else $error("hold latch");

  property p_nohold_b;
    @(posedge clock) disable iff (rst)
      (strap_r == `CSR_FAM_B) |=> !hold_r;
  endproperty
  a_nohold_b: assert property (p_nohold_b) else $error("b held");

  sequence s_stop_end;
    (strap_r == `CSR_FAM_A && $past(strap_r) == `CSR_FAM_A
     && !stop_clock_req && $past(stop_clock_req));
  endsequence
  property p_expire;
    @(posedge clock) disable iff (rst)
      s_stop_end ##0 (!stop_clock_req && strap_r == `CSR_FAM_A) [*5]
        |=> !hold_r;
  endproperty
  a_expire: assert property (p_expire) else $error("hold length");

  property p_hold_len;
    @(posedge clock) disable iff (rst)
      s_stop_end ##0 (!stop_clock_req && strap_r == `CSR_FAM_A) [*4]
        |=> hold_r;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("short");

  property p_stophold;
    @(posedge clock) disable iff (rst)
      (stop_clock_req && strap_r == `CSR_FAM_A) |=> hold_r;
  endproperty
  a_stophold: assert property (p_stophold) else $error("no hold");

  property p_sus_low;
    @(posedge clock) disable iff (rst)
      (hard_go && st_r == csr_pkg::CSR_IDLE) |=> !suspend_plane_a;
  endproperty
  a_sus_low: assert property (p_sus_low) else $error("sus low");

  property p_start;
    @(posedge clock) disable iff (rst)
      (hard_go && st_r == csr_pkg::CSR_IDLE)
        |=> (st_r == csr_pkg::CSR_PULSE);
  endproperty
  a_start: assert property (p_start) else $error("no start");

  property p_cold;
    @(posedge clock) disable iff (rst)
      cold_boot_start |-> $past(st_r) == csr_pkg::CSR_COLD;
  endproperty
  a_cold: assert property (p_cold) else $error("cold path");

  property p_pol;
    @(posedge clock) disable iff (rst)
      (strap_r == `CSR_FAM_A && $past(strap_r) == `CSR_FAM_A
       && !$past(hold_r))
        |-> cpu_init_out == $past(init_src);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity a");
endmodule : csr_sideband
`default_nettype wire

/* src/csr_cfg.svh */
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH
`define CSR_FAM_A        1'b0
`define CSR_FAM_B        1'b1
`define CSR_HOLD_CLKS    3'h5
`define CSR_HARD_BIT     2
`define CSR_SYS_BIT      1
`define CSR_SUS_RTC      3'h4
`endif

/* src/csr_pkg.sv */
package csr_pkg;
  typedef enum logic [2:0] {
    CSR_IDLE  = 3'b001,
    CSR_PULSE = 3'b010,
    CSR_COLD  = 3'b100
  } csr_state_t;
endpackage : csr_pkg

/* verif/csr_psu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module csr_psu_model (
  // Clock
  input  wire logic clock,
  // Suspend planes and fault command
  input  wire logic suspend_plane_a,
  input  wire logic suspend_plane_b,
  input  wire logic suspend_plane_c,
  input  wire logic drop_en,
  // Supply status
  output var logic  power_good
);
  logic [1:0] up_r = 2'h3;
  logic       pg_r = 1'b1;
  assign power_good = pg_r;
  // Supply sags while drop_en is set and any plane is off
  always @(posedge clock) begin
    if (drop_en
        && !(suspend_plane_a & suspend_plane_b & suspend_plane_c)) begin
      pg_r <= 1'b0;
      up_r <= 2'h0;
    end else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    else pg_r <= 1'b1;
  end
endmodule : csr_psu_model
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {logic s; logic [4:0] src; logic [4:0] exp;} csr_row_t;
  logic clock = 1'b0, rst = 1'b1, proc_type_strap = 1'b0, stop_clock_req = 1'b0;
  logic nmi_src = 1'b0, mgmt_irq_src = 1'b0, cpu_irq_src = 1'b0;
  logic init_src = 1'b0, reset_src = 1'b0, rst_port_wr = 1'b0, rtc_tick = 1'b0;
  logic drop_en = 1'b0, power_good, nmi_out, mgmt_irq_out, cpu_irq_out;
  logic cpu_init_out, cpu_reset_out, suspend_plane_a, suspend_plane_b;
  logic suspend_plane_c, hard_reset_done, cold_boot_start, ok;
  logic [7:0] rst_port_data = 8'h00;
  int miscompares = 0, comparisons = 0, tk = 0, n;
  csr_row_t rows [7] = '{'{0, 5'h00, 5'h00}, '{0, 5'h1f, 5'h1f},
    '{0, 5'h15, 5'h15}, '{1, 5'h00, 5'h03}, '{1, 5'h1f, 5'h1c},
    '{1, 5'h0a, 5'h09}, '{1, 5'h15, 5'h16}};
  wire [4:0] outs = {nmi_out, mgmt_irq_out, cpu_irq_out, cpu_init_out,
    cpu_reset_out};
  wire [2:0] sus = {suspend_plane_a, suspend_plane_b, suspend_plane_c};
  csr_sideband csr_sideband_i (.clock, .rst, .proc_type_strap,
    .stop_clock_req, .nmi_src, .mgmt_irq_src, .cpu_irq_src, .init_src,
    .reset_src, .rst_port_wr, .rst_port_data, .rtc_tick, .power_good,
    .nmi_out, .mgmt_irq_out, .cpu_irq_out, .cpu_init_out, .cpu_reset_out,
    .suspend_plane_a, .suspend_plane_b, .suspend_plane_c, .hard_reset_done,
    .cold_boot_start);
  csr_psu_model csr_psu_model_i (.clock, .suspend_plane_a, .suspend_plane_b,
    .suspend_plane_c, .drop_en, .power_good);
  always #5 clock = ~clock;
  always @(negedge clock) begin
    tk <= (tk == 6) ? 0 : tk + 1;
    rtc_tick <= (tk == 6);
  end
  task automatic chk(string nm, logic [4:0] seen, logic [4:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic cyc(int k);
    repeat (k) @(negedge clock);
  endtask : cyc
  task automatic src(logic [4:0] v);
    {nmi_src, mgmt_irq_src, cpu_irq_src, init_src, reset_src} = v;
  endtask : src
  task automatic wrp(logic [7:0] d);
    rst_port_data = d;
    rst_port_wr = 1'b1;
    cyc(1);
    rst_port_wr = 1'b0;
  endtask : wrp
  initial begin
    cyc(4);
    chk("reset_outs", outs, 5'h01);
    chk("reset_sus", sus, 5'h07);
    rst = 1'b0;
    foreach (rows[i]) begin
      proc_type_strap = rows[i].s;
      src(rows[i].src);
      cyc(3);
      chk("sideband", outs, rows[i].exp);
    end
    proc_type_strap = 1'b0;
    src(5'h1c);
    cyc(3);
    stop_clock_req = 1'b1;
    cyc(1);
    src(5'h00);
    cyc(3);
    chk("held", outs, 5'h1c);
    stop_clock_req = 1'b0;
    cyc(4);
    chk("held_after", outs, 5'h1c);
    n = 0;
    while (outs !== 5'h00 && n < 6) begin
      cyc(1);
      n++;
    end
    chk("released", outs, 5'h00);
    chk("release_at", 5'(n), 5'h02);
    proc_type_strap = 1'b1;
    src(5'h1c);
    stop_clock_req = 1'b1;
    cyc(3);
    src(5'h00);
    cyc(2);
    chk("unlatched", outs, 5'h03);
    stop_clock_req = 1'b0;
    proc_type_strap = 1'b0;
    cyc(3);
    wrp(8'h04);
    cyc(2);
    chk("no_reset_a", sus, 5'h07);
    wrp(8'h02);
    cyc(2);
    chk("no_reset_b", sus, 5'h07);
    wrp(8'h06);
    chk("sus_low", sus, 5'h00);
    n = 0;
    while (sus !== 3'h7 && n < 60) begin
      if (n == 1) chk("cpu_rst", cpu_reset_out, 5'h01);
      rst_port_wr = (n == 5);
      cyc(1);
      n++;
    end
    chk("pulse_len", (n >= 21 && n <= 28), 5'h01);
    chk("done", hard_reset_done, 5'h01);
    drop_en = 1'b1;
    cyc(3);
    wrp(8'h06);
    ok = 1'b0;
    n = 0;
    while (!ok && n < 200) begin
      cyc(1);
      if (hard_reset_done === 1'b1) chk("no_done", 5'h01, 5'h00);
      ok = (cold_boot_start === 1'b1);
      n++;
    end
    chk("cold_boot", ok, 5'h01);
    drop_en = 1'b0;
    wrp(8'h06);
    cyc(2);
    chk("mid_sus_low", sus, 5'h00);
    rst = 1'b1;
    cyc(2);
    chk("mid_rst_sus", sus, 5'h07);
    chk("mid_rst_outs", outs, 5'h01);
    rst = 1'b0;
    cyc(3);
    chk("post_rst_outs", outs, 5'h00);
    chk("post_rst_sus", sus, 5'h07);
    finish_test();
  end
endmodule : tb
`default_nettype wire
